// ===== src/cgu_defs.vh
/*
 Constants for the clock generation unit: source codes, divider limits,
 reset values and timing counts. Assumes inclusion by cgu_top.v only.
*/
`ifndef CGU_DEFS_VH
`define CGU_DEFS_VH

// Destination source codes
`define CGU_SRC_RC       3'h0
`define CGU_SRC_OSC      3'h1
`define CGU_SRC_MAIN_PLL 3'h2
`define CGU_SRC_ALT_PLL  3'h3

// Observation output source codes
`define CGU_OBS_CPU      3'h0
`define CGU_OBS_OSC      3'h1
`define CGU_OBS_RC       3'h2
`define CGU_OBS_USB      3'h3
`define CGU_OBS_RTC32K   3'h4
`define CGU_OBS_WDT      3'h5

// Reference edges before a PLL reports lock
`define CGU_LOCK_EDGES   8'h10
// Half period of the 1 Hz tick in 32 kHz edges (32768 / 2)
`define CGU_RTC_HALF     15'h4000
`define CGU_POST_MIN     4'h1

`endif

// ===== src/cgu_top.v
/*
 Clock generation unit: main and alternate PLL emulation, per-destination
 source select and divider, RTC and watchdog clock outputs, observation
 output. All oscillator pins are asynchronous and are synchronised to
 core_clk, which must run well above every generated clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cgu_defs.vh"

////////////////////////////////////////////////////////////////////////////
module cgu_pll #(
  parameter HAS_RC = 1
) (
  input  wire       clk,
  input  wire       nrst,
  input  wire       ce,
  input  wire       rc_in,
  input  wire       osc_in,
  input  wire       ref_sel,
  input  wire       en,
  input  wire [4:0] mult,
  input  wire [1:0] post,
  output wire       locked,
  output wire       powered,
  output wire       pll_out
);
  reg        en_reg;
  reg        ref_prev_reg;
  reg        ref_sel_reg;
  reg  [4:0] mult_reg;
  reg  [3:0] post_reg;
  reg  [5:0] burst_reg;
  reg  [3:0] post_cnt_reg;
  reg  [7:0] lock_cnt_reg;
  reg        out_reg;
  wire       ref_lvl;
  wire       ref_rise;
  wire [3:0] post_ratio;

  // Alternate has no internal RC path
  assign ref_lvl  = (HAS_RC != 0 && ref_sel_reg) ? rc_in : osc_in;
  assign ref_rise = ref_lvl & ~ref_prev_reg;
  // Half ratio 1,2,4,8 gives full ratio 2..16
  assign post_ratio = 4'h1 << post;
  assign locked   = (lock_cnt_reg == `CGU_LOCK_EDGES);
  assign powered  = en_reg;
  assign pll_out  = out_reg;

  always @(posedge clk or negedge nrst)
  begin
    // Disabled and powered down out of reset
    if (!nrst)
    begin
      en_reg       <= 1'b0;
      ref_prev_reg <= 1'b0;
      ref_sel_reg  <= 1'b0;
      mult_reg     <= 5'h00;
      post_reg     <= `CGU_POST_MIN;
      burst_reg    <= 6'h00;
      post_cnt_reg <= 4'h0;
      lock_cnt_reg <= 8'h00;
      out_reg      <= 1'b0;
    end
    else if (ce)
    begin
      en_reg       <= en;
      ref_prev_reg <= ref_lvl;
      if (!en_reg)
      begin
        // Config taken only while off, so it never glitches a running clock
        ref_sel_reg  <= ref_sel;
        mult_reg     <= mult;
        post_reg     <= post_ratio;
        burst_reg    <= 6'h00;
        post_cnt_reg <= 4'h0;
        lock_cnt_reg <= 8'h00;
        out_reg      <= 1'b0;
      end
      else
      begin
        if (ref_rise && !locked)
          lock_cnt_reg <= lock_cnt_reg + 8'h01;
        if (ref_rise)
          burst_reg <= {1'b0, mult_reg} + 6'h01;
        else if (burst_reg != 6'h00)
          burst_reg <= burst_reg - 6'h01;
        // Toggle every half ratio ticks, even duty
        if (burst_reg != 6'h00 && !ref_rise && locked)
        begin
          if (post_cnt_reg + 4'h1 >= post_reg)
          begin
            post_cnt_reg <= 4'h0;
            out_reg      <= ~out_reg;
          end
          else
            post_cnt_reg <= post_cnt_reg + 4'h1;
        end
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
module cgu_clk_dest (
  input  wire       clk,
  input  wire       nrst,
  input  wire       ce,
  input  wire [7:0] src_vec,
  input  wire [2:0] sel,
  input  wire [4:0] div,
  output wire       clk_out
);
  reg  [2:0] sel_reg;
  reg  [4:0] div_reg;
  reg  [4:0] cnt_reg;
  reg        prev_reg;
  reg        out_reg;
  wire       cur;
  wire       pending;

  // Source select then divider; divider 0 gates the clock off
  assign cur     = src_vec[sel_reg];
  assign pending = (sel != sel_reg) || (div != div_reg);
  assign clk_out = out_reg;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sel_reg  <= 3'h0;
      div_reg  <= 5'h01;
      cnt_reg  <= 5'h00;
      prev_reg <= 1'b0;
      out_reg  <= 1'b0;
    end
    else if (ce)
    begin
      // Switch only while output is low, no runt pulses
      if (pending && !out_reg)
      begin
        sel_reg  <= sel;
        div_reg  <= div;
        cnt_reg  <= 5'h00;
        prev_reg <= src_vec[sel];
      end
      else
      begin
        prev_reg <= cur;
        if (cur && !prev_reg && div_reg != 5'h00)
        begin
          if (cnt_reg + 5'h01 >= div_reg)
          begin
            cnt_reg <= 5'h00;
            out_reg <= ~out_reg;
          end
          else
            cnt_reg <= cnt_reg + 5'h01;
        end
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
module cgu_top #(
  parameter [14:0] RTC_HALF = `CGU_RTC_HALF
) (
  input  wire       core_clk,
  input  wire       nrst,
  input  wire       ce,
  input  wire       internal_rc_oscillator_pin,
  input  wire       main_osc_pin,
  input  wire       rtc_osc_pin,
  input  wire       wdt_osc_pin,
  input  wire       main_pll_en,
  input  wire       main_pll_ref_rc,
  input  wire [4:0] main_pll_mult,
  input  wire [1:0] main_pll_post,
  input  wire       alt_pll_en,
  input  wire [4:0] alt_pll_mult,
  input  wire [1:0] alt_pll_post,
  input  wire [2:0] cpu_src_sel,
  input  wire [4:0] cpu_div,
  input  wire [2:0] usb_src_sel,
  input  wire [4:0] usb_div,
  input  wire [2:0] periph_src_sel,
  input  wire [4:0] periph_div,
  input  wire [2:0] obs_src_sel,
  input  wire [4:0] obs_div,
  input  wire       wdt_enabled,
  input  wire       wdt_osc_sw_run,
  output wire       main_pll_locked,
  output wire       main_pll_powered,
  output wire       main_pll_clk,
  output wire       alt_pll_locked,
  output wire       alt_pll_powered,
  output wire       alt_pll_clk,
  output wire       cpu_clk,
  output wire       usb_clk,
  output wire       periph_clk,
  output wire       clock_observation_output,
  output wire       rtc_tick_1hz,
  output wire       rtc_clk_32k,
  output wire       wdt_clk,
  output wire       wdt_osc_run
);
  reg  [3:0]  sync1_reg;
  reg  [3:0]  sync2_reg;
  reg         rtc_prev_reg;
  reg  [14:0] rtc_cnt_reg;
  reg         rtc_tick_reg;
  reg         wdt_run_reg;
  reg         wdt_clk_reg;
  reg         wdt_prev_reg;
  wire        rc_s;
  wire        osc_s;
  wire        rtc_s;
  wire        wdt_s;
  wire [7:0]  dest_src;
  wire [7:0]  obs_src;

  assign rc_s  = sync2_reg[0];
  assign osc_s = sync2_reg[1];
  assign rtc_s = sync2_reg[2];
  assign wdt_s = sync2_reg[3];

  // Pins are asynchronous; two stages before any use
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end
    else if (ce)
    begin
      sync1_reg <= {wdt_osc_pin, rtc_osc_pin, main_osc_pin,
                    internal_rc_oscillator_pin};
      sync2_reg <= sync1_reg;
    end
  end

  cgu_pll #(.HAS_RC(1)) u_main_pll (
    .clk     (core_clk),
    .nrst    (nrst),
    .ce      (ce),
    .rc_in   (rc_s),
    .osc_in  (osc_s),
    .ref_sel (main_pll_ref_rc),
    .en      (main_pll_en),
    .mult    (main_pll_mult),
    .post    (main_pll_post),
    .locked  (main_pll_locked),
    .powered (main_pll_powered),
    .pll_out (main_pll_clk)
  );

  // Alternate reference tied to main oscillator
  cgu_pll #(.HAS_RC(0)) u_alt_pll (
    .clk     (core_clk),
    .nrst    (nrst),
    .ce      (ce),
    .rc_in   (1'b0),
    .osc_in  (osc_s),
    .ref_sel (1'b0),
    .en      (alt_pll_en),
    .mult    (alt_pll_mult),
    .post    (alt_pll_post),
    .locked  (alt_pll_locked),
    .powered (alt_pll_powered),
    .pll_out (alt_pll_clk)
  );

  // USB may pick the main PLL code as well as the alternate
  assign dest_src = {4'h0, alt_pll_clk, main_pll_clk, osc_s, rc_s};

  cgu_clk_dest u_cpu (
    .clk     (core_clk),
    .nrst    (nrst),
    .ce      (ce),
    .src_vec (dest_src),
    .sel     (cpu_src_sel),
    .div     (cpu_div),
    .clk_out (cpu_clk)
  );

  cgu_clk_dest u_usb (
    .clk     (core_clk),
    .nrst    (nrst),
    .ce      (ce),
    .src_vec (dest_src),
    .sel     (usb_src_sel),
    .div     (usb_div),
    .clk_out (usb_clk)
  );

  cgu_clk_dest u_periph (
    .clk     (core_clk),
    .nrst    (nrst),
    .ce      (ce),
    .src_vec (dest_src),
    .sel     (periph_src_sel),
    .div     (periph_div),
    .clk_out (periph_clk)
  );

  // Watchdog clock among observation sources
  // Bit order follows the observation source codes
  assign obs_src = {2'h0, wdt_clk_reg, rtc_s, usb_clk, rc_s, osc_s, cpu_clk};

  cgu_clk_dest u_obs (
    .clk     (core_clk),
    .nrst    (nrst),
    .ce      (ce),
    .src_vec (obs_src),
    .sel     (obs_src_sel),
    .div     (obs_div),
    .clk_out (clock_observation_output)
  );

  // 32 kHz passes out, 1 Hz tick by halving count
  assign rtc_clk_32k  = rtc_s;
  assign rtc_tick_1hz = rtc_tick_reg;
  // Watchdog clock apart from the main tree
  assign wdt_clk      = wdt_clk_reg;
  assign wdt_osc_run  = wdt_run_reg;

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rtc_prev_reg <= 1'b0;
      rtc_cnt_reg  <= 15'h0000;
      rtc_tick_reg <= 1'b0;
      wdt_run_reg  <= 1'b0;
      wdt_clk_reg  <= 1'b0;
      wdt_prev_reg <= 1'b0;
    end
    else if (ce)
    begin
      rtc_prev_reg <= rtc_s;
      if (rtc_s && !rtc_prev_reg)
      begin
        if (rtc_cnt_reg + 15'h0001 >= RTC_HALF)
        begin
          rtc_cnt_reg  <= 15'h0000;
          rtc_tick_reg <= ~rtc_tick_reg;
        end
        else
          rtc_cnt_reg <= rtc_cnt_reg + 15'h0001;
      end
      // Watchdog enable overrides the software stop
      wdt_run_reg  <= wdt_enabled | wdt_osc_sw_run;
      wdt_prev_reg <= wdt_s;
      // Start on a pin rise, stop only when low: no runt either way
      if (wdt_clk_reg)
        wdt_clk_reg <= wdt_s;
      else
        wdt_clk_reg <= wdt_run_reg & wdt_s & ~wdt_prev_reg;
    end
  end
endmodule
`default_nettype wire

// ===== dv/cgu_props.sv
/*
 Port checker for cgu_top: PLL power-up, gating, watchdog run, no runts.
 Assumes a bind onto cgu_top and a single core_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module cgu_props (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic main_pll_en,
  input wire logic main_pll_powered,
  input wire logic main_pll_locked,
  input wire logic main_pll_clk,
  input wire logic alt_pll_en,
  input wire logic alt_pll_powered,
  input wire logic alt_pll_locked,
  input wire logic alt_pll_clk,
  input wire logic cpu_clk,
  input wire logic usb_clk,
  input wire logic wdt_enabled,
  input wire logic wdt_osc_sw_run,
  input wire logic wdt_osc_run
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////
  // Lock needs many reference edges, never within a few core cycles
  sequence s_main_wait;
    main_pll_powered ##0 (!main_pll_locked)[*8];
  endsequence
  sequence s_alt_wait;
    alt_pll_powered ##0 (!alt_pll_locked)[*8];
  endsequence
  property p_main_off;
    (!main_pll_en)[*8] |-> !main_pll_powered && !main_pll_locked
      && !main_pll_clk;
  endproperty
  property p_alt_off;
    (!alt_pll_en)[*8] |-> !alt_pll_powered && !alt_pll_locked && !alt_pll_clk;
  endproperty
  property p_main_up;
    $rose(main_pll_en) |=> s_main_wait;
  endproperty
  property p_alt_up;
    $rose(alt_pll_en) |=> s_alt_wait;
  endproperty
  property p_main_gate;
    $rose(main_pll_clk) |-> main_pll_locked;
  endproperty
  property p_alt_gate;
    $rose(alt_pll_clk) |-> alt_pll_locked;
  endproperty
  property p_wdt_forced;
    wdt_enabled |=> wdt_osc_run;
  endproperty
  property p_wdt_idle;
    (!wdt_enabled && !wdt_osc_sw_run)[*2] |-> !wdt_osc_run;
  endproperty
  property p_cpu_runt;
    $changed(cpu_clk) |=> $stable(cpu_clk);
  endproperty
  property p_usb_runt;
    $changed(usb_clk) |=> $stable(usb_clk);
  endproperty
  ////////////////////////////////////////////////////////////////////////
  a_main_off: assert property (p_main_off)
    else $error("main pll active while disabled");
  a_alt_off: assert property (p_alt_off)
    else $error("alternate pll active while disabled");
  a_main_up: assert property (p_main_up)
    else $error("main pll power or lock timing wrong");
  a_alt_up: assert property (p_alt_up)
    else $error("alternate pll power or lock timing wrong");
  a_main_gate: assert property (p_main_gate)
    else $error("main pll clock before lock");
  a_alt_gate: assert property (p_alt_gate)
    else $error("alternate pll clock before lock");
  a_wdt_forced: assert property (p_wdt_forced)
    else $error("watchdog oscillator stopped while enabled");
  a_wdt_idle: assert property (p_wdt_idle)
    else $error("watchdog oscillator runs unrequested");
  a_cpu_runt: assert property (p_cpu_runt)
    else $error("runt pulse on cpu clock");
  a_usb_runt: assert property (p_usb_runt)
    else $error("runt pulse on usb clock");
endmodule
`default_nettype wire

// ===== dv/cgu_osc_model.sv
/*
 Free-running oscillator sources for the clock unit.
 Assumes a 5 ns core clock; edges land on whole ns, off its rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module cgu_osc_model #(
  parameter RC_HALF  = 60,
  parameter OSC_HALF = 40,
  parameter RTC_HALF = 20,
  parameter WDT_HALF = 50
) (
  output var logic internal_rc_oscillator_pin,
  output var logic main_osc_pin,
  output var logic rtc_osc_pin,
  output var logic wdt_osc_pin
);
  // All periods exceed four core cycles so the synchronisers keep up
  initial
  begin
    internal_rc_oscillator_pin = 1'b0;
    main_osc_pin = 1'b0;
    rtc_osc_pin = 1'b0;
    wdt_osc_pin = 1'b0;
  end
  always #(RC_HALF) internal_rc_oscillator_pin = ~internal_rc_oscillator_pin;
  always #(OSC_HALF) main_osc_pin = ~main_osc_pin;
  always #(RTC_HALF) rtc_osc_pin = ~rtc_osc_pin;
  always #(WDT_HALF) wdt_osc_pin = ~wdt_osc_pin;
endmodule
`default_nettype wire

// ===== dv/tb.sv
/*
 Self-checking bench for cgu_top: counts rising edges in fixed windows.
 Assumes the oscillator model and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int W = 960;
  // Short tick count so the tick output is seen within one window
  localparam logic [14:0] RTC_TB = 15'h0004;
  logic core_clk, nrst, ce, main_pll_en, main_pll_ref_rc, alt_pll_en;
  logic wdt_enabled, wdt_osc_sw_run;
  logic [4:0] main_pll_mult, alt_pll_mult, cpu_div, usb_div, periph_div;
  logic [4:0] obs_div;
  logic [1:0] main_pll_post, alt_pll_post;
  logic [2:0] cpu_src_sel, usb_src_sel, periph_src_sel, obs_src_sel;
  wire internal_rc_oscillator_pin, main_osc_pin, rtc_osc_pin, wdt_osc_pin;
  wire main_pll_locked, main_pll_powered, main_pll_clk, alt_pll_locked;
  wire alt_pll_powered, alt_pll_clk, cpu_clk, usb_clk, periph_clk;
  wire clock_observation_output, rtc_tick_1hz, rtc_clk_32k, wdt_clk;
  wire wdt_osc_run;
  wire [8:0] mon = {rtc_tick_1hz, wdt_clk, rtc_clk_32k,
                    clock_observation_output, periph_clk, usb_clk, cpu_clk,
                    alt_pll_clk, main_pll_clk};
  int exp_q[$], tol_q[$], got, e, t, failures, cmp_count;
  // Edges per window: internal RC, osc, main pll, alt pll
  int src[4] = '{40, 60, 80, 120};
  int obs[6] = '{20, 30, 20, 20, 60, 24};
  logic [31:0] lfsr;
  event got_ev;
  cgu_osc_model cgu_osc_model_i (.internal_rc_oscillator_pin, .main_osc_pin,
    .rtc_osc_pin, .wdt_osc_pin);
  cgu_top #(.RTC_HALF(RTC_TB)) cgu_top_i (.core_clk, .nrst, .ce,
    .internal_rc_oscillator_pin, .main_osc_pin, .rtc_osc_pin, .wdt_osc_pin,
    .main_pll_en, .main_pll_ref_rc, .main_pll_mult, .main_pll_post,
    .alt_pll_en, .alt_pll_mult, .alt_pll_post,
    .cpu_src_sel, .cpu_div, .usb_src_sel, .usb_div, .periph_src_sel,
    .periph_div, .obs_src_sel, .obs_div, .wdt_enabled, .wdt_osc_sw_run,
    .main_pll_locked, .main_pll_powered, .main_pll_clk, .alt_pll_locked,
    .alt_pll_powered, .alt_pll_clk, .cpu_clk, .usb_clk, .periph_clk,
    .clock_observation_output, .rtc_tick_1hz, .rtc_clk_32k, .wdt_clk,
    .wdt_osc_run);
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task note(input int ex, input int tl);
    exp_q.push_back(ex);
    tol_q.push_back(tl);
  endtask
  task give(input int g);
    got = g;
    -> got_ev;
    cyc(1);
  endtask
  task meas(input int idx);
    int n;
    logic p;
    n = 0;
    p = mon[idx];
    repeat (W)
    begin
      @(posedge core_clk);
      // Sample once the edge's updates have settled
      #1;
      if (mon[idx] === 1'b1 && p === 1'b0) n++;
      p = mon[idx];
    end
    give(n);
  endtask
  task end_sim;
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Nonzero window edge counts allow one edge of phase slack, zero counts none
  initial forever
  begin
    @(got_ev);
    cmp_count++;
    e = exp_q.pop_front();
    t = tol_q.pop_front();
    if (got < e - t || got > e + t)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
    end
  end
  initial
  begin
    #250000;
    failures++;
    end_sim;
  end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {main_pll_en, main_pll_ref_rc, alt_pll_en, wdt_enabled} = 4'h0;
    {main_pll_mult, alt_pll_mult, main_pll_post, alt_pll_post} = 14'h0000;
    {cpu_src_sel, usb_src_sel, periph_src_sel, obs_src_sel} = 12'h000;
    {cpu_div, usb_div, periph_div, obs_div} = 20'h08421;
    wdt_osc_sw_run = 1'b0;
    ce = 1'b1;
    lfsr = 32'h21DA5C43;
    nrst = 1'b0;
    cyc(2);
    nrst = 1'b1;
    cyc(20);
    note(0, 0);
    give({main_pll_powered, main_pll_locked, alt_pll_powered,
      alt_pll_locked} === 4'h0 ? 0 : 1);
    note(0, 0);
    meas(0);
    main_pll_mult = 5'h03;
    alt_pll_mult = 5'h07;
    alt_pll_post = 2'h1;
    cyc(1);
    main_pll_en = 1'b1;
    alt_pll_en = 1'b1;
    cyc(400);
    note(120, 1);
    meas(0);
    note(120, 1);
    meas(1);
    // Change while running must be ignored
    main_pll_mult = 5'h00;
    cyc(40);
    note(120, 1);
    meas(0);
    main_pll_en = 1'b0;
    cyc(10);
    main_pll_ref_rc = 1'b1;
    main_pll_mult = 5'h03;
    cyc(1);
    main_pll_en = 1'b1;
    cyc(600);
    note(80, 1);
    meas(0);
    note(120, 1);
    meas(1);
    for (int c = 0; c < 4; c++)
      for (int d = 1; d < 3; d++)
      begin
        cpu_src_sel = c[2:0];
        cpu_div = d[4:0];
        cyc(200);
        note(src[c] / (2 * d), 1);
        meas(2);
      end
    cpu_div = 5'h00;
    cyc(200);
    note(0, 0);
    meas(2);
    repeat (3)
    begin
      lfsr = nxt(lfsr);
      periph_src_sel = {1'b0, lfsr[1:0]};
      periph_div = {3'h0, lfsr[3:2]} + 5'h01;
      cyc(200);
      note(src[lfsr[1:0]] / (2 * (lfsr[3:2] + 1)), 1);
      meas(4);
    end
    alt_pll_en = 1'b0;
    usb_src_sel = 3'h2;
    cpu_src_sel = 3'h2;
    cpu_div = 5'h01;
    wdt_enabled = 1'b1;
    cyc(200);
    note(40, 1);
    meas(3);
    for (int c = 0; c < 6; c++)
    begin
      obs_src_sel = c[2:0];
      cyc(200);
      note(obs[c], 1);
      meas(5);
    end
    note(120, 1);
    meas(6);
    note(1, 0);
    give(wdt_osc_run === 1'b1);
    note(48, 1);
    meas(7);
    wdt_enabled = 1'b0;
    cyc(20);
    note(0, 0);
    meas(7);
    wdt_osc_sw_run = 1'b1;
    cyc(20);
    note(48, 1);
    meas(7);
    note(120 / (2 * RTC_TB), 1);
    meas(8);
    // Clock enable low must freeze the cpu destination clock
    ce = 1'b0;
    note(0, 0);
    meas(2);
    ce = 1'b1;
    end_sim;
  end
endmodule
bind cgu_top cgu_props cgu_props_i (.core_clk, .nrst, .main_pll_en,
  .main_pll_powered, .main_pll_locked, .main_pll_clk, .alt_pll_en,
  .alt_pll_powered, .alt_pll_locked, .alt_pll_clk, .cpu_clk, .usb_clk,
  .wdt_enabled, .wdt_osc_sw_run, .wdt_osc_run);
`default_nettype wire
